// ### pkg/fcl_pkg.sv
// Constants shared by the flash command controller and its bus cycle engine
package fcl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin widths and clock
  localparam int ADDR_W        = 23;
  localparam int DQ_W          = 16;
  localparam int CLK_PERIOD_NS = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Pin timing in ns; least times round up to whole cycles
  localparam int SETUP_NS      = 10;
  localparam int WE_LOW_NS     = 70;
  localparam int RECOVER_NS    = 30;
  localparam int ACCESS_NS     = 100;
  localparam int PAGE_NS       = 25;
  localparam int RESET_LOW_NS  = 100;
  localparam int RESET_REC_NS  = 150;

  localparam logic [15:0] SETUP_CYC     = 16'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] WE_CYC        = 16'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RECOVER_CYC   = 16'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] ACCESS_CYC    = 16'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PAGE_CYC      = 16'((PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RESET_LOW_CYC = 16'((RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RESET_REC_CYC = 16'((RESET_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Device command bytes and the configuration code mask
  localparam logic [7:0] CMD_STS_CONFIG = 8'hb8;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_READ_ID    = 8'h90;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STAT  = 8'h70;
  localparam logic [7:0] CMD_CLR_STAT   = 8'h50;
  localparam logic [7:0] CFG_CODE_MASK  = 8'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Device status byte bits
  localparam int SR_READY   = 7;
  localparam int SR_ERASE   = 5;
  localparam int SR_PROGRAM = 4;
  localparam int SR_PROTECT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Host register map (byte addresses) and fields
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_RCR    = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_WORD0  = 8'h20;
  localparam int         RCR_RM_BIT = 16;
  localparam logic [1:0] STS_MODE_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Operations that software starts through REG_CMD
  typedef enum logic [2:0] {
    OP_CONFIG     = 3'h0,
    OP_SET_LOCK   = 3'h1,
    OP_CLEAR_LOCK = 3'h2,
    OP_READ_STAT  = 3'h3,
    OP_READ_ID    = 3'h4,
    OP_READ_ARRAY = 3'h5,
    OP_CLR_STAT   = 3'h6,
    OP_RESET      = 3'h7
  } fcl_op_e;

endpackage

// ### design/fcl_bus_cycle.sv
// One asynchronous write or read cycle on the flash pins, with page-read continuation
`timescale 1ns/100ps
module fcl_bus_cycle (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      start,
  input  wire logic                      isWrite,
  input  wire logic                      keepOpen,
  input  wire logic [fcl_pkg::ADDR_W-1:0] cycAddr,
  input  wire logic [fcl_pkg::DQ_W-1:0]   cycWdata,
  input  wire logic [fcl_pkg::DQ_W-1:0]   dqIn,
  output logic                           done,
  output logic [fcl_pkg::DQ_W-1:0]        rdData,
  output logic [fcl_pkg::ADDR_W-1:0]      addrOut,
  output logic [fcl_pkg::DQ_W-1:0]        dqOut,
  output logic                           dqOe,
  output logic                           chipEnable0N,
  output logic                           outEnableN,
  output logic                           writeEnableN
);
  import fcl_pkg::*;

  typedef enum logic [2:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_RECOVER, BC_OPEN} fcl_bc_e;

  fcl_bc_e                 state_reg,  state_next;
  logic [15:0]             cnt_reg,    cnt_next;
  logic                    wr_reg,     wr_next;
  logic                    open_reg,   open_next;
  logic [ADDR_W-1:0]       addr_reg,   addr_next;
  logic [DQ_W-1:0]         wdat_reg,   wdat_next;
  logic [DQ_W-1:0]         rd_reg,     rd_next;
  logic                    done_reg,   done_next;
  logic                    ceN_reg,    ceN_next;
  logic                    oeN_reg,    oeN_next;
  logic                    weN_reg,    weN_next;
  logic                    dqOe_reg,   dqOe_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    wr_next    = wr_reg;
    open_next  = open_reg;
    addr_next  = addr_reg;
    wdat_next  = wdat_reg;
    rd_next    = rd_reg;
    done_next  = 1'b0;
    ceN_next   = ceN_reg;
    oeN_next   = oeN_reg;
    weN_next   = weN_reg;
    dqOe_next  = dqOe_reg;
    case (state_reg)
      BC_IDLE: begin
        if (start) begin
          wr_next    = isWrite;
          open_next  = keepOpen & ~isWrite;
          addr_next  = cycAddr;
          wdat_next  = cycWdata;
          ceN_next   = 1'b0;
          dqOe_next  = isWrite;
          oeN_next   = isWrite;
          cnt_next   = SETUP_CYC;
          state_next = BC_SETUP;
        end
      end
      BC_SETUP: begin
        if (cnt_reg <= 16'h0001) begin
          weN_next   = ~wr_reg;
          cnt_next   = wr_reg ? WE_CYC : ACCESS_CYC;
          state_next = BC_STROBE;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      BC_STROBE: begin
        if (cnt_reg <= 16'h0001) begin
          // Data sits stable on the pins by the end of the access time
          if (!wr_reg) begin
            rd_next = dqIn;
          end
          if (open_reg) begin
            done_next  = 1'b1;
            state_next = BC_OPEN;
          end else begin
            weN_next   = 1'b1;
            oeN_next   = 1'b1;
            cnt_next   = RECOVER_CYC;
            state_next = BC_RECOVER;
          end
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      BC_RECOVER: begin
        ceN_next  = 1'b1;
        dqOe_next = 1'b0;
        if (cnt_reg <= 16'h0001) begin
          done_next  = 1'b1;
          state_next = BC_IDLE;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      BC_OPEN: begin
        // CE and OE stay low; only the address moves, so page timing applies
        if (start) begin
          open_next  = keepOpen;
          addr_next  = cycAddr;
          cnt_next   = PAGE_CYC;
          state_next = BC_STROBE;
        end
      end
      default: state_next = BC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= BC_IDLE;
      cnt_reg   <= 16'h0000;
      wr_reg    <= 1'b0;
      open_reg  <= 1'b0;
      addr_reg  <= '0;
      wdat_reg  <= '0;
      rd_reg    <= '0;
      done_reg  <= 1'b0;
      ceN_reg   <= 1'b1;
      oeN_reg   <= 1'b1;
      weN_reg   <= 1'b1;
      dqOe_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      wr_reg    <= wr_next;
      open_reg  <= open_next;
      addr_reg  <= addr_next;
      wdat_reg  <= wdat_next;
      rd_reg    <= rd_next;
      done_reg  <= done_next;
      ceN_reg   <= ceN_next;
      oeN_reg   <= oeN_next;
      weN_reg   <= weN_next;
      dqOe_reg  <= dqOe_next;
    end
  end

  assign done         = done_reg;
  assign rdData       = rd_reg;
  assign addrOut      = addr_reg;
  assign dqOut        = wdat_reg;
  assign dqOe         = dqOe_reg;
  assign chipEnable0N = ceN_reg;
  assign outEnableN   = oeN_reg;
  assign writeEnableN = weN_reg;

endmodule // fcl_bus_cycle

// ### design/fcl_flash_ctrl.sv
// Host controller issuing configuration, lock-bit and identifier commands to a parallel flash
`timescale 1ns/100ps
module fcl_flash_ctrl #(
  parameter int          PAGE_WORDS    = 8,
  parameter int          CLEAR_RETRIES = 2,
  parameter logic [7:0]  LOCK_SET_CONF = 8'h01,
  parameter logic [7:0]  LOCK_CLR_CONF = 8'hd0
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic [7:0]                busAddr,
  input  wire logic [31:0]               busWdata,
  input  wire logic                      busWr,
  input  wire logic                      busRd,
  output logic [31:0]                    busRdata,
  output logic [fcl_pkg::ADDR_W-1:0]      flashAddr,
  input  wire logic [fcl_pkg::DQ_W-1:0]   flashDqIn,
  output logic [fcl_pkg::DQ_W-1:0]        flashDqOut,
  output logic                           flashDqOe,
  output logic                           chipEnable0N,
  output logic                           outEnableN,
  output logic                           writeEnableN,
  output logic                           resetPowerdownN,
  input  wire logic                      eventOutPin
);
  import fcl_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_PRE_CMD, S_PRE_RD, S_CMD1, S_CMD2, S_POLL_RD,
    S_RD_CMD, S_RD_WORD, S_RST_LOW, S_RST_REC
  } fcl_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer state
  fcl_state_e             state_reg,    state_next;
  fcl_op_e                op_reg,       op_next;
  logic                   issued_reg,   issued_next;
  logic [15:0]            cnt_reg,      cnt_next;
  logic [7:0]             idx_reg,      idx_next;
  logic [7:0]             retry_reg,    retry_next;
  logic [ADDR_W-1:0]      argAddr_reg,  argAddr_next;
  logic [7:0]             argData_reg,  argData_next;
  logic                   pageMode_reg, pageMode_next;
  logic [1:0]             stsMode_reg,  stsMode_next;
  logic [7:0]             statByte_reg, statByte_next;
  logic                   cfgBad_reg,   cfgBad_next;
  logic                   protect_reg,  protect_next;
  logic                   clrFail_reg,  clrFail_next;
  logic                   rpN_reg,      rpN_next;
  logic [DQ_W-1:0]        words_reg [PAGE_WORDS];
  logic [DQ_W-1:0]        words_next [PAGE_WORDS];

  // Bus cycle request
  logic                   cycNeed;
  logic                   cycWrite;
  logic                   cycKeep;
  logic [ADDR_W-1:0]      cycAddr;
  logic [7:0]             cycByte;
  logic                   cycDone;
  logic [DQ_W-1:0]        cycRd;

  // Event pin tracking and register port
  logic [2:0]             evSync_reg,   evSync_next;
  logic                   evLevel_reg,  evLevel_next;
  logic [7:0]             pulseCnt_reg, pulseCnt_next;
  logic [31:0]            rdata_reg,    rdata_next;
  logic                   busy;
  logic                   go;

  assign busy = (state_reg != S_IDLE);
  assign go   = busWr && (busAddr == REG_CMD) && !busy;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle to issue in each state
  always_comb begin
    cycNeed  = 1'b0;
    cycWrite = 1'b1;
    cycKeep  = 1'b0;
    cycAddr  = '0;
    cycByte  = CMD_READ_STAT;
    case (state_reg)
      S_PRE_CMD: cycNeed = 1'b1;
      S_PRE_RD,
      S_POLL_RD: begin
        cycNeed  = 1'b1;
        cycWrite = 1'b0;
      end
      S_CMD1: begin
        cycNeed = 1'b1;
        cycAddr = argAddr_reg;
        cycByte = (op_reg == OP_CONFIG) ? CMD_STS_CONFIG : CMD_LOCK_SETUP;
        if (op_reg == OP_CLR_STAT) begin
          cycByte = CMD_CLR_STAT;
        end
      end
      S_CMD2: begin
        cycNeed = 1'b1;
        cycAddr = argAddr_reg;
        case (op_reg)
          OP_CONFIG:   cycByte = argData_reg & CFG_CODE_MASK;
          OP_SET_LOCK: cycByte = LOCK_SET_CONF;
          default:     cycByte = LOCK_CLR_CONF;
        endcase
      end
      S_RD_CMD: begin
        cycNeed = 1'b1;
        cycByte = (op_reg == OP_READ_ID) ? CMD_READ_ID :
                  (op_reg == OP_READ_ARRAY) ? CMD_READ_ARRAY : CMD_READ_STAT;
      end
      S_RD_WORD: begin
        cycNeed  = 1'b1;
        cycWrite = 1'b0;
        cycAddr  = argAddr_reg + ADDR_W'(idx_reg);
        // Only array reads may burst; status and identifier stay single
        cycKeep  = (op_reg == OP_READ_ARRAY) && pageMode_reg &&
                   (idx_reg < 8'(PAGE_WORDS - 1));
      end
      default: cycNeed = 1'b0;
    endcase
  end

  fcl_bus_cycle u_cycle (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .start        (cycNeed && !issued_reg),
    .isWrite      (cycWrite),
    .keepOpen     (cycKeep),
    .cycAddr      (cycAddr),
    .cycWdata     ({8'h00, cycByte}),
    .dqIn         (flashDqIn),
    .done         (cycDone),
    .rdData       (cycRd),
    .addrOut      (flashAddr),
    .dqOut        (flashDqOut),
    .dqOe         (flashDqOe),
    .chipEnable0N (chipEnable0N),
    .outEnableN   (outEnableN),
    .writeEnableN (writeEnableN)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_next    = state_reg;
    op_next       = op_reg;
    issued_next   = issued_reg | (cycNeed & ~issued_reg);
    cnt_next      = cnt_reg;
    idx_next      = idx_reg;
    retry_next    = retry_reg;
    argAddr_next  = argAddr_reg;
    argData_next  = argData_reg;
    pageMode_next = pageMode_reg;
    stsMode_next  = stsMode_reg;
    statByte_next = statByte_reg;
    cfgBad_next   = cfgBad_reg;
    protect_next  = protect_reg;
    clrFail_next  = clrFail_reg;
    rpN_next      = rpN_reg;
    words_next    = words_reg;
    if (cycDone) begin
      issued_next = 1'b0;
    end
    if (!busy && busWr && busAddr == REG_ADDR) begin
      argAddr_next = busWdata[ADDR_W-1:0];
    end
    if (!busy && busWr && busAddr == REG_DATA) begin
      argData_next = busWdata[7:0];
    end
    if (!busy && busWr && busAddr == REG_RCR) begin
      pageMode_next = busWdata[RCR_RM_BIT];
    end
    case (state_reg)
      S_IDLE: begin
        if (go) begin
          op_next     = fcl_op_e'(busWdata[2:0]);
          idx_next    = 8'h00;
          retry_next  = 8'h00;
          cfgBad_next = 1'b0;
          case (fcl_op_e'(busWdata[2:0]))
            OP_CONFIG, OP_SET_LOCK, OP_CLEAR_LOCK: state_next = S_PRE_CMD;
            OP_CLR_STAT:                           state_next = S_CMD1;
            OP_RESET: begin
              rpN_next   = 1'b0;
              cnt_next   = RESET_LOW_CYC;
              state_next = S_RST_LOW;
            end
            default:                               state_next = S_RD_CMD;
          endcase
        end
      end
      S_PRE_CMD: if (cycDone) state_next = S_PRE_RD;
      S_PRE_RD: begin
        // Each read toggles OE, so the device refreshes its status latch
        if (cycDone && cycRd[SR_READY]) begin
          state_next = S_CMD1;
        end
      end
      S_CMD1: begin
        if (cycDone) begin
          state_next = (op_reg == OP_CLR_STAT) ? S_IDLE : S_CMD2;
          if (op_reg == OP_CLR_STAT) begin
            cfgBad_next  = 1'b0;
            protect_next = 1'b0;
            clrFail_next = 1'b0;
          end
        end
      end
      S_CMD2: if (cycDone) state_next = S_POLL_RD;
      S_POLL_RD: begin
        if (cycDone && cycRd[SR_READY]) begin
          // Kept whole so software sees a lockout abort beside unchanged lock bits
          statByte_next = cycRd[7:0];
          state_next    = S_IDLE;
          if (op_reg == OP_CONFIG) begin
            cfgBad_next = cycRd[SR_ERASE] & cycRd[SR_PROGRAM];
            if (!(cycRd[SR_ERASE] & cycRd[SR_PROGRAM])) begin
              stsMode_next = argData_reg[1:0];
            end
          end else if (op_reg == OP_SET_LOCK) begin
            protect_next = cycRd[SR_PROTECT];
          end else if (cycRd[SR_ERASE]) begin
            // Lock bits are unknown after an aborted clear, so repeat it
            if (retry_reg < 8'(CLEAR_RETRIES)) begin
              retry_next = retry_reg + 8'h01;
              state_next = S_PRE_CMD;
            end else begin
              clrFail_next = 1'b1;
            end
          end
        end
      end
      S_RD_CMD: if (cycDone) state_next = S_RD_WORD;
      S_RD_WORD: begin
        if (cycDone) begin
          words_next[idx_reg[$clog2(PAGE_WORDS)-1:0]] = cycRd;
          if (op_reg == OP_READ_STAT) begin
            statByte_next = cycRd[7:0];
          end
          if (cycKeep) begin
            idx_next = idx_reg + 8'h01;
          end else begin
            state_next = S_IDLE;
          end
        end
      end
      S_RST_LOW: begin
        if (cnt_reg <= 16'h0001) begin
          rpN_next   = 1'b1;
          cnt_next   = RESET_REC_CYC;
          state_next = S_RST_REC;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
        stsMode_next  = STS_MODE_RST;
        pageMode_next = 1'b0;
      end
      S_RST_REC: begin
        if (cnt_reg <= 16'h0001) begin
          state_next = S_IDLE;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event pin: three flops, a change counts once stages two and three agree
  always_comb begin
    evSync_next   = {evSync_reg[1:0], eventOutPin};
    evLevel_next  = (evSync_reg[1] == evSync_reg[2]) ? evSync_reg[2] : evLevel_reg;
    pulseCnt_next = pulseCnt_reg;
    if (busWr && busAddr == REG_STATUS) begin
      pulseCnt_next = 8'h00;
    end
    // A falling edge in a pulse mode marks a completion; set wins over clear
    if (stsMode_reg != STS_MODE_RST && evLevel_reg && !evLevel_next) begin
      pulseCnt_next = pulseCnt_next + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle after the strobe
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (busRd) begin
      if (busAddr == REG_CMD) begin
        rdata_next = {28'h0000000, busy, op_reg};
      end else if (busAddr == REG_ADDR) begin
        rdata_next = 32'(argAddr_reg);
      end else if (busAddr == REG_DATA) begin
        rdata_next = {24'h000000, argData_reg};
      end else if (busAddr == REG_RCR) begin
        rdata_next = 32'(pageMode_reg) << RCR_RM_BIT;
      end else if (busAddr == REG_STATUS) begin
        rdata_next = {8'h00, pulseCnt_reg, statByte_reg, 1'b0, clrFail_reg, protect_reg,
                      cfgBad_reg, stsMode_reg, evLevel_reg, busy};
      end else if (busAddr >= REG_WORD0 && busAddr < REG_WORD0 + 8'(4 * PAGE_WORDS) &&
                   busAddr[1:0] == 2'b00) begin
        rdata_next = 32'(words_reg[busAddr[$clog2(PAGE_WORDS)+1:2]]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg    <= S_RST_LOW;
      op_reg       <= OP_RESET;
      issued_reg   <= 1'b0;
      cnt_reg      <= RESET_LOW_CYC;
      idx_reg      <= 8'h00;
      retry_reg    <= 8'h00;
      argAddr_reg  <= '0;
      argData_reg  <= 8'h00;
      pageMode_reg <= 1'b0;
      stsMode_reg  <= STS_MODE_RST;
      statByte_reg <= 8'h00;
      cfgBad_reg   <= 1'b0;
      protect_reg  <= 1'b0;
      clrFail_reg  <= 1'b0;
      rpN_reg      <= 1'b0;
      evSync_reg   <= 3'h7;
      evLevel_reg  <= 1'b1;
      pulseCnt_reg <= 8'h00;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      state_reg    <= state_next;
      op_reg       <= op_next;
      issued_reg   <= issued_next;
      cnt_reg      <= cnt_next;
      idx_reg      <= idx_next;
      retry_reg    <= retry_next;
      argAddr_reg  <= argAddr_next;
      argData_reg  <= argData_next;
      pageMode_reg <= pageMode_next;
      stsMode_reg  <= stsMode_next;
      statByte_reg <= statByte_next;
      cfgBad_reg   <= cfgBad_next;
      protect_reg  <= protect_next;
      clrFail_reg  <= clrFail_next;
      rpN_reg      <= rpN_next;
      evSync_reg   <= evSync_next;
      evLevel_reg  <= evLevel_next;
      pulseCnt_reg <= pulseCnt_next;
      rdata_reg    <= rdata_next;
    end
  end

  // Captured words are data storage; reset leaves them alone
  always_ff @(posedge sys_clk) begin
    words_reg <= words_next;
  end

  assign busRdata        = rdata_reg;
  assign resetPowerdownN = rpN_reg;

endmodule // fcl_flash_ctrl

// ### test/fcl_flash_ctrl_asserts.sv
// Port assertions for the flash command controller
`timescale 1ns/100ps
module fcl_flash_ctrl_asserts (
  input wire logic        sys_clk, rst, busRd, flashDqOe, chipEnable0N, outEnableN,
  input wire logic        writeEnableN, resetPowerdownN,
  input wire logic [7:0]  busAddr,
  input wire logic [31:0] busRdata,
  input wire logic [15:0] flashDqOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_we_in_ce: assert property (!writeEnableN |-> !chipEnable0N && flashDqOe)
    else $error("write strobe outside chip enable");
  chk_oe_no_drive: assert property (!outEnableN |-> !flashDqOe)
    else $error("data driven during read");
  chk_rp_quiet: assert property (!resetPowerdownN |-> chipEnable0N && writeEnableN)
    else $error("bus cycle during reset pulse");
  chk_we_width: assert property ($fell(writeEnableN) |-> !writeEnableN [*8])
    else $error("write strobe too short");
  chk_ce_setup: assert property ($fell(writeEnableN) |-> !$past(chipEnable0N, 2))
    else $error("chip enable setup short");
  chk_wr_stable: assert property (!writeEnableN ##1 !writeEnableN |-> $stable(flashDqOut))
    else $error("write data moved");
  chk_rcr_zero: assert property (busRd && busAddr == 8'h0c |=> busRdata[15:0] == 16'h0)
    else $error("reserved read mode bits set");
  chk_rp_width: assert property ($rose(resetPowerdownN) |-> !$past(resetPowerdownN, 8))
    else $error("reset pulse too short");
endmodule // fcl_flash_ctrl_asserts
bind fcl_flash_ctrl fcl_flash_ctrl_asserts u_fcl_flash_ctrl_asserts (.sys_clk, .rst, .busRd,
  .flashDqOe, .chipEnable0N, .outEnableN, .writeEnableN, .resetPowerdownN, .busAddr, .busRdata,
  .flashDqOut);

// ### test/fcl_flash_model.sv
// Behavioural flash device answering configuration, lock and identifier commands
`timescale 1ns/100ps
module fcl_flash_model (
  input wire logic [22:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic        chipEnable0N, outEnableN, writeEnableN, resetPowerdownN,
  output logic [15:0]     flashDqIn,
  output logic            eventOutPin
);
  logic [7:0] sr = 8'h80, prev = 8'hff, cmd;
  logic [5:0] blk;
  logic [1:0] pinMode = 2'h0;
  logic [63:0] locks = 64'h0;
  logic stMode = 1'b0, idMode = 1'b0;
  logic [15:0] lastQ = 16'h0, drvQ;
  always @(negedge resetPowerdownN) {pinMode, stMode, idMode, prev} = {2'h0, 2'b00, 8'hff};
  // Only strobes inside chip enable count, so the power-up edge of the pin is ignored
  always @(posedge writeEnableN) if (!chipEnable0N) begin
    cmd = flashDqOut[7:0];
    blk = flashAddr[22:17];
    if (prev == 8'hb8 && cmd[7:2] != 6'h00) sr[5:4] = 2'b11;
    else if (prev == 8'hb8) pinMode = cmd[1:0];
    else if (prev == 8'h60) begin
      sr[7] = 1'b0;
      // Busy time kept short so the bench stays brief
      #300 locks = cmd == 8'hd0 ? 64'h0 : locks | 64'h1 << blk;
      sr[7] = 1'b1;
    end else begin
      stMode = cmd inside {8'h70, 8'h60, 8'hb8};
      idMode = cmd == 8'h90;
    end
    prev = prev inside {8'hb8, 8'h60} ? 8'h00 : cmd;
  end
  assign drvQ = stMode ? {8'h0, sr[7], sr[7] ? sr[6:0] : ~lastQ[6:0]}
    : idMode ? {15'h0, locks[flashAddr[22:17]]} : flashAddr[15:0];
  // No pull on the data lines, so a released bus shows the inverse of the last word
  assign flashDqIn = chipEnable0N | outEnableN ? ~lastQ : drvQ;
  always @(posedge outEnableN) if (!chipEnable0N) lastQ = drvQ;
  assign eventOutPin = pinMode != 2'h0 | sr[7];
endmodule // fcl_flash_model

// ### test/fcl_flash_ctrl_tb.sv
// Self-checking bench for the flash command controller
`timescale 1ns/100ps
module fcl_flash_ctrl_tb;
  import fcl_pkg::*;
  logic sys_clk = 0, rst = 1, busWr = 0, busRd = 0, flashDqOe, chipEnable0N, outEnableN;
  logic writeEnableN, resetPowerdownN, eventOutPin;
  logic [7:0] busAddr = 8'h0;
  logic [31:0] busWdata = 32'h0, busRdata, v;
  logic [22:0] flashAddr;
  logic [15:0] flashDqIn, flashDqOut;
  int err_total = 0, total_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  fcl_flash_ctrl u_fcl_flash_ctrl (.sys_clk, .rst, .busAddr, .busWdata, .busWr, .busRd,
    .busRdata, .flashAddr, .flashDqIn, .flashDqOut, .flashDqOe, .chipEnable0N, .outEnableN,
    .writeEnableN, .resetPowerdownN, .eventOutPin);
  fcl_flash_model u_fcl_flash_model (.flashAddr, .flashDqOut, .chipEnable0N, .outEnableN,
    .writeEnableN, .resetPowerdownN, .flashDqIn, .eventOutPin);
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin err_total++; $display("[ERR] %s expected %h seen %h", s, e, g); end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk) {busAddr, busWdata, busWr} <= {a, d, 1'b1};
    @(posedge sys_clk) busWr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk) {busAddr, busRd} <= {a, 1'b1};
    @(posedge sys_clk) busRd <= 1'b0;
    #1 v = busRdata;
  endtask
  task automatic idle();
    v = '1;
    for (int i = 0; i < 3000 && v[3] !== 1'b0; i++) rd(REG_CMD);
    chk("idle wait", 32'h0, 32'(v[3]));
  endtask
  task automatic op(logic [2:0] o);
    wr(REG_CMD, {29'h0, o});
    idle();
  endtask
  task automatic tReset();
    idle(); rd(REG_STATUS); chk("pin mode", 32'h0, 32'(v[3:2]));
    rd(REG_RCR); chk("read mode", 32'h0, v);
    wr(REG_RCR, 32'h0001_0000); rd(REG_RCR); chk("read mode set", 32'h10000, v);
    rd(8'h14); chk("unmapped", 32'h0, v);
  endtask
  task automatic tConfig();
    for (int c = 3; c >= 0; c--) begin
      wr(REG_DATA, 32'(c) | 32'hfc); op(OP_CONFIG); rd(REG_STATUS);
      chk("pin mode", 32'(c), 32'(v[3:2]));
      chk("code flag", 32'h0, 32'(v[4]));
    end
    chk("level pin", 32'h1, 32'(eventOutPin));
  endtask
  task automatic tLock();
    wr(REG_ADDR, 32'h000a_0000); wr(REG_CMD, 32'(OP_SET_LOCK));
    wr(REG_CMD, 32'(OP_CONFIG)); idle(); rd(REG_CMD);
    chk("op kept", 32'(OP_SET_LOCK), 32'(v[2:0]));
    rd(REG_STATUS); chk("ready byte", 32'h80, 32'(v[15:8]));
    chk("pulse count", 32'h0, 32'(v[23:16]));
    op(OP_READ_ID); rd(REG_WORD0); chk("lock code", 32'h1, 32'(v[15:0]));
    op(OP_CLEAR_LOCK); op(OP_READ_ID); rd(REG_WORD0);
    chk("lock cleared", 32'h0, 32'(v[15:0]));
  endtask
  task automatic tArray();
    wr(REG_RCR, 32'h0001_0000); wr(REG_ADDR, 32'h0000_1230); op(OP_READ_ARRAY);
    rd(8'h3c); chk("page word", 32'h1237, v);
    op(OP_CLR_STAT); op(OP_READ_STAT); rd(REG_STATUS);
    chk("stat byte", 32'h80, 32'(v[15:8]));
    wr(REG_DATA, 32'h3); op(OP_CONFIG); op(OP_RESET); rd(REG_STATUS);
    chk("pin reset", 32'h0, 32'(v[3:2]));
    rd(REG_RCR); chk("mode reset", 32'h0, v);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    tReset(); tConfig(); tLock(); tArray();
    end_sim();
  end
  // Whole run is under two thousand cycles; this allows over forty times that
  initial begin
    #400000 err_total++;
    end_sim();
  end
endmodule // fcl_flash_ctrl_tb
